//--- verilog/msp_params.svh
// Constants for the sleep and protected configuration register block.
// Assumes a 10 MHz core clock; included by the package users by bare name.
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define MSP_A_DEV_STATUS 8'h00
`define MSP_A_ALERT 8'h20
`define MSP_A_FAULT 8'h21
`define MSP_A_ADC_CTRL 8'h30
`define MSP_A_IO_CTRL 8'h31
`define MSP_A_KEY 8'h3a
`define MSP_A_RESET 8'h3c
`define MSP_A_TRIGGER 8'h3f
`define MSP_A_RSVD 8'h3e
`define MSP_A_G3_FIRST 8'h40
`define MSP_A_G3_LAST 8'h4b
`define MSP_A_G3_USER 8'h48

// ****************************************************************
// Key values and reset values
// ****************************************************************
`define MSP_KEY_WRITE 8'h35
`define MSP_KEY_RELOAD 8'h27
`define MSP_KEY_BURN 8'h91
`define MSP_KEY_RESET 8'ha5
`define MSP_ALERT_RST 8'h80
`define MSP_ZERO8 8'h00

// ****************************************************************
// Bit positions
// ****************************************************************
`define MSP_DS_CONVERSION_DONE_PIN 0
`define MSP_DS_OTP_CORRECTED_FLAG 3
`define MSP_DS_ALERT 5
`define MSP_DS_FAULT 6
`define MSP_AL_SLEEP 2
`define MSP_AL_I_FAULT 3
`define MSP_AL_ECC_ERR 5
`define MSP_AL_PARITY 6
`define MSP_FL_CRC 0
`define MSP_IO_TS1 0
`define MSP_IO_TS2 1
`define MSP_IO_SLEEP 2
`define MSP_ADC_ON 0
`define MSP_CFG_CRC_DIS 0
`define MSP_IOCFG_IDX 1

// ****************************************************************
// Timing
// ****************************************************************
`define MSP_CLK_MHZ 10
`define MSP_WARM_US 100
`define MSP_BURN_US 1000

`endif

//--- verilog/msp_pkg.sv
// Types shared by the sleep and protected configuration register block.
// Assumes msp_params.svh supplies the numeric constants.
package msp_pkg;

  // Host register write as delivered by the packet layer.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } msp_wr_s;

  // Power state of the monitor.
  typedef enum logic [1:0] {
    PW_AWAKE,
    PW_DRAIN,
    PW_SLEEP,
    PW_WARM
  } msp_pwr_e;

  // One-time memory sequencer state.
  typedef enum logic [1:0] {
    OT_IDLE,
    OT_LOAD,
    OT_BURN,
    OT_WAIT
  } msp_otp_e;

endpackage : msp_pkg

//--- verilog/msp_otp_mem.sv
// One-time programmable memory with Hamming SECDED check on every read.
// Assumes the sequencer in msp_regs drives one read or one burn per cycle.
`timescale 1ns/1ps
module msp_otp_mem #(
  parameter int WORDS = 12,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic lock_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic cor_o,
  output logic err_o,
  output logic locked_o
);

  // ****************************************************************
  // Code functions
  // ****************************************************************
  // Four Hamming check bits over eight data bits.
  function automatic logic [3:0] msp_ham(input logic [7:0] d);
    msp_ham[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    msp_ham[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    msp_ham[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    msp_ham[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
  endfunction : msp_ham

  // Data bit position that a nonzero syndrome points at, or 8 for a check bit.
  function automatic logic [3:0] msp_pos(input logic [3:0] s);
    case (s)
      4'h3: msp_pos = 4'h0;
      4'h5: msp_pos = 4'h1;
      4'h6: msp_pos = 4'h2;
      4'h7: msp_pos = 4'h3;
      4'h9: msp_pos = 4'h4;
      4'ha: msp_pos = 4'h5;
      4'hb: msp_pos = 4'h6;
      4'hc: msp_pos = 4'h7;
      default: msp_pos = 4'h8;
    endcase
  endfunction : msp_pos

  // Cells hold data, check bits and an overall parity bit; unburnt cells are 0.
  logic [12:0] cell_reg [WORDS];
  logic [12:0] cell_next [WORDS];
  logic locked_reg, locked_next;
  logic [7:0] rdata_reg, rdata_next;
  logic cor_reg, cor_next, err_reg, err_next;

  // Burning only raises bits and is refused once the array is locked.
  always_comb begin
    logic [12:0] c;
    logic [3:0] syn;
    logic [3:0] p;
    logic par;
    c = '0;
    syn = '0;
    p = '0;
    par = 1'b0;
    cell_next = cell_reg;
    locked_next = locked_reg | lock_i;
    if (wr_en_i && !locked_reg && (int'(addr_i) < WORDS)) begin
      cell_next[addr_i] = cell_reg[addr_i] |
        {^{msp_ham(wdata_i), wdata_i}, msp_ham(wdata_i), wdata_i};
    end
    rdata_next = rdata_reg;
    cor_next = 1'b0;
    err_next = 1'b0;
    if (rd_en_i && (int'(addr_i) < WORDS)) begin
      c = cell_reg[addr_i];
      syn = msp_ham(c[7:0]) ^ c[11:8];
      par = ^c;
      rdata_next = c[7:0];
      if (syn != 4'h0 && par) begin
        cor_next = 1'b1;
        p = msp_pos(syn);
        if (p != 4'h8) begin
          rdata_next[p[2:0]] = ~c[p[2:0]];
        end
      end else if (syn != 4'h0) begin
        err_next = 1'b1;
      end else if (par) begin
        cor_next = 1'b1;
      end
    end
  end

  // Registers the array and the read port.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < WORDS; i++) begin
        cell_reg[i] <= '0;
      end
      locked_reg <= 1'b0;
      rdata_reg <= '0;
      cor_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      cell_reg <= cell_next;
      locked_reg <= locked_next;
      rdata_reg <= rdata_next;
      cor_reg <= cor_next;
      err_reg <= err_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign cor_o = cor_reg;
  assign err_o = err_reg;
  assign locked_o = locked_reg;

endmodule : msp_otp_mem

//--- verilog/msp_regs.sv
// Register bank with sleep control and protected configuration loaded from one-time memory.
// Assumes the packet layer delivers decoded register reads and writes on clk_i.
`timescale 1ns/1ps
`include "msp_params.svh"
module msp_regs
  import msp_pkg::*;
#(
  parameter int G3_WORDS = 12,
  parameter int WARM_CYC = `MSP_WARM_US * `MSP_CLK_MHZ,
  parameter int BURN_CYC = `MSP_BURN_US * `MSP_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_i,
  input wire msp_wr_s wr_req_i,
  input wire logic pkt_end_i,
  input wire logic crc_ok_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire logic conv_busy_i,
  input wire logic [7:0] alert_src_i,
  input wire logic [7:0] fault_src_i,
  input wire logic program_voltage_pin_i,
  output logic conversion_done_pin_o,
  output logic alert_o,
  output logic fault_o,
  output logic regulator_en_o,
  output logic comparator_en_o,
  output logic adc_en_o,
  output logic [1:0] thermistor_bias_bits_o,
  output logic [8*G3_WORDS-1:0] config_o
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  // True for an address inside the protected configuration group.
  function automatic logic msp_is_g3(input logic [7:0] a);
    msp_is_g3 = (a >= `MSP_A_G3_FIRST) && (a <= `MSP_A_G3_LAST);
  endfunction : msp_is_g3

  // Index of a protected register inside its group.
  function automatic logic [3:0] msp_g3_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `MSP_A_G3_FIRST;
    msp_g3_idx = d[3:0];
  endfunction : msp_g3_idx

  // ****************************************************************
  // State
  // ****************************************************************
  msp_pwr_e pwr_reg, pwr_next;
  msp_otp_e ot_reg, ot_next;
  logic [7:0] alert_reg, alert_next, fault_reg, fault_next;
  logic [7:0] snap_al_reg, snap_al_next, snap_fl_reg, snap_fl_next;
  logic [7:0] io_reg, io_next, adc_reg, adc_next, trig_reg, trig_next;
  logic [8:0] g3_reg [G3_WORDS];
  logic [8:0] g3_next [G3_WORDS];
  logic otp_corrected_flag_reg, otp_corrected_flag_next, armed_reg, armed_next;
  logic pend_reg, pend_next;
  msp_wr_s pend_wr_reg, pend_wr_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] idx_reg, idx_next;
  logic cap_reg, cap_next;
  logic [3:0] cap_idx_reg, cap_idx_next;
  logic conversion_done_pin_reg, conversion_done_pin_next;
  logic [7:0] rdata_reg, rdata_next;
  logic vpp_meta_reg, vpp_reg;
  logic otp_rd, otp_wr, otp_lock, otp_cor, otp_err, otp_locked;
  logic [7:0] otp_rdata;
  logic [3:0] otp_addr;
  logic asleep, par_bad;
  logic [7:0] dev_status;

  // Program voltage arrives from a pin and passes two flip-flops.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vpp_meta_reg <= 1'b0;
      vpp_reg <= 1'b0;
    end else begin
      vpp_meta_reg <= program_voltage_pin_i;
      vpp_reg <= vpp_meta_reg;
    end
  end

  msp_otp_mem #(
    .WORDS(G3_WORDS),
    .AW(4)
  ) u_otp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .rd_en_i(otp_rd),
    .wr_en_i(otp_wr),
    .lock_i(otp_lock),
    .addr_i(otp_addr),
    .wdata_i(g3_reg[idx_reg][7:0]),
    .rdata_o(otp_rdata),
    .cor_o(otp_cor),
    .err_o(otp_err),
    .locked_o(otp_locked)
  );

  // Parity watch over the protected group and derived status.
  always_comb begin
    par_bad = 1'b0;
    for (int i = 0; i < G3_WORDS; i++) begin
      par_bad = par_bad | (^g3_reg[i]);
    end
    asleep = (pwr_reg == PW_SLEEP);
    dev_status = '0;
    dev_status[`MSP_DS_CONVERSION_DONE_PIN] = conversion_done_pin_reg;
    dev_status[`MSP_DS_OTP_CORRECTED_FLAG] = otp_corrected_flag_reg;
    dev_status[`MSP_DS_ALERT] = alert_o;
    dev_status[`MSP_DS_FAULT] = fault_o;
  end

  // ****************************************************************
  // Next-state logic for registers, power and memory sequencing
  // ****************************************************************
  always_comb begin
    logic commit, soft_rst, reload;
    msp_wr_s w;
    commit = 1'b0;
    soft_rst = 1'b0;
    reload = 1'b0;
    w = pend_wr_reg;
    pwr_next = pwr_reg;
    ot_next = ot_reg;
    alert_next = alert_reg;
    fault_next = fault_reg;
    snap_al_next = snap_al_reg;
    snap_fl_next = snap_fl_reg;
    io_next = io_reg;
    adc_next = adc_reg;
    trig_next = trig_reg;
    g3_next = g3_reg;
    otp_corrected_flag_next = otp_corrected_flag_reg;
    armed_next = armed_reg;
    pend_next = pend_reg;
    pend_wr_next = pend_wr_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    cap_next = 1'b0;
    cap_idx_next = idx_reg;
    otp_rd = 1'b0;
    otp_wr = 1'b0;
    otp_lock = 1'b0;
    otp_addr = idx_reg;
    conversion_done_pin_next = (pwr_reg == PW_SLEEP) | !conv_busy_i;
    // Write held until the packet ends and its CRC is judged.
    if (wr_i) begin
      pend_next = 1'b1;
      pend_wr_next = wr_req_i;
    end
    if (pkt_end_i && pend_reg) begin
      pend_next = 1'b0;
      if (crc_ok_i || g3_reg[`MSP_IOCFG_IDX][`MSP_CFG_CRC_DIS]) begin
        commit = 1'b1;
      end
    end
    // Host write, one register, allowed in every power state.
    if (commit) begin
      armed_next = 1'b0;
      case (w.addr)
        `MSP_A_ALERT: alert_next = w.data;
        `MSP_A_FAULT: fault_next = w.data;
        `MSP_A_ADC_CTRL: adc_next = w.data;
        `MSP_A_IO_CTRL: io_next = w.data;
        `MSP_A_TRIGGER: trig_next = w.data;
        `MSP_A_RESET: soft_rst = (w.data == `MSP_KEY_RESET);
        `MSP_A_KEY: begin
          armed_next = (w.data == `MSP_KEY_WRITE);
          reload = (w.data == `MSP_KEY_RELOAD);
        end
        default: begin
          if (msp_is_g3(w.addr) && armed_reg && w.addr < `MSP_A_G3_USER) begin
            g3_next[msp_g3_idx(w.addr)] = {^w.data, w.data};
          end
        end
      endcase
    end
    // Sources are gated off while asleep; hardware sets win over host clears.
    if (!asleep) begin
      alert_next = alert_next | alert_src_i;
      fault_next = fault_next | fault_src_i;
      if (par_bad && ot_reg != OT_LOAD) begin
        alert_next[`MSP_AL_PARITY] = 1'b1;
      end
    end
    if (pkt_end_i && pend_reg && !crc_ok_i && !g3_reg[`MSP_IOCFG_IDX][`MSP_CFG_CRC_DIS]) begin
      fault_next[`MSP_FL_CRC] = 1'b1;
    end
    // Power sequencing.
    case (pwr_reg)
      PW_AWAKE: begin
        if (io_reg[`MSP_IO_SLEEP]) begin
          pwr_next = conv_busy_i ? PW_DRAIN : PW_SLEEP;
        end
      end
      PW_DRAIN: begin
        if (!conv_busy_i) begin
          pwr_next = PW_SLEEP;
        end
      end
      PW_SLEEP: begin
        if (!io_reg[`MSP_IO_SLEEP]) begin
          alert_next = snap_al_reg;
          fault_next = snap_fl_reg;
          cnt_next = '0;
          pwr_next = PW_WARM;
        end
      end
      PW_WARM: begin
        cnt_next = cnt_reg + 16'h0001;
        if (int'(cnt_reg) >= WARM_CYC - 1) begin
          pwr_next = PW_AWAKE;
        end
      end
      default: pwr_next = PW_AWAKE;
    endcase
    if (pwr_reg != PW_SLEEP && pwr_next == PW_SLEEP) begin
      snap_al_next = alert_next;
      snap_fl_next = fault_next;
      alert_next[`MSP_AL_SLEEP] = 1'b1;
    end
    // One-time memory sequencing: load, burn and self-timed wait.
    case (ot_reg)
      OT_IDLE: begin
        if (trig_reg == `MSP_KEY_BURN && vpp_reg && !otp_locked) begin
          idx_next = '0;
          ot_next = OT_BURN;
        end
      end
      OT_LOAD: begin
        otp_rd = 1'b1;
        cap_next = 1'b1;
        if (int'(idx_reg) == G3_WORDS - 1) begin
          ot_next = OT_IDLE;
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      OT_BURN: begin
        otp_wr = 1'b1;
        if (int'(idx_reg) == G3_WORDS - 1) begin
          cnt_next = '0;
          ot_next = OT_WAIT;
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      OT_WAIT: begin
        cnt_next = cnt_reg + 16'h0001;
        if (int'(cnt_reg) >= BURN_CYC - 1) begin
          otp_lock = 1'b1;
          trig_next = '0;
          ot_next = OT_IDLE;
        end
      end
      default: ot_next = OT_IDLE;
    endcase
    // Loaded words with their Hamming outcome.
    if (cap_reg) begin
      g3_next[cap_idx_reg] = {^otp_rdata, otp_rdata};
      if (otp_cor) begin
        otp_corrected_flag_next = 1'b1;
      end
      if (otp_err) begin
        alert_next[`MSP_AL_ECC_ERR] = 1'b1;
        alert_next[`MSP_AL_I_FAULT] = 1'b1;
      end
    end
    if ((reload || soft_rst) && ot_reg != OT_BURN && ot_reg != OT_WAIT) begin
      idx_next = '0;
      ot_next = OT_LOAD;
    end
    if (soft_rst) begin
      alert_next = `MSP_ALERT_RST;
      fault_next = `MSP_ZERO8;
      io_next = `MSP_ZERO8;
      adc_next = `MSP_ZERO8;
      otp_corrected_flag_next = 1'b0;
      armed_next = 1'b0;
      pwr_next = PW_AWAKE;
    end
  end

  // Registered read port; unmapped addresses answer zero.
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_i) begin
      case (rd_addr_i)
        `MSP_A_DEV_STATUS: rdata_next = dev_status;
        `MSP_A_ALERT: rdata_next = alert_reg;
        `MSP_A_FAULT: rdata_next = fault_reg;
        `MSP_A_ADC_CTRL: rdata_next = adc_reg;
        `MSP_A_IO_CTRL: rdata_next = io_reg;
        `MSP_A_TRIGGER: rdata_next = trig_reg;
        default: rdata_next = msp_is_g3(rd_addr_i) ? g3_reg[msp_g3_idx(rd_addr_i)][7:0] : `MSP_ZERO8;
      endcase
    end
  end

  // Registers all state but the program voltage flip-flops; reset starts a load of the protected group.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_reg <= PW_AWAKE;
      ot_reg <= OT_LOAD;
      alert_reg <= `MSP_ALERT_RST;
      fault_reg <= `MSP_ZERO8;
      snap_al_reg <= `MSP_ZERO8;
      snap_fl_reg <= `MSP_ZERO8;
      io_reg <= `MSP_ZERO8;
      adc_reg <= `MSP_ZERO8;
      trig_reg <= `MSP_ZERO8;
      for (int i = 0; i < G3_WORDS; i++) begin
        g3_reg[i] <= '0;
      end
      otp_corrected_flag_reg <= 1'b0;
      armed_reg <= 1'b0;
      pend_reg <= 1'b0;
      pend_wr_reg <= '0;
      cnt_reg <= '0;
      idx_reg <= '0;
      cap_reg <= 1'b0;
      cap_idx_reg <= '0;
      conversion_done_pin_reg <= 1'b0;
      rdata_reg <= `MSP_ZERO8;
    end else begin
      pwr_reg <= pwr_next;
      ot_reg <= ot_next;
      alert_reg <= alert_next;
      fault_reg <= fault_next;
      snap_al_reg <= snap_al_next;
      snap_fl_reg <= snap_fl_next;
      io_reg <= io_next;
      adc_reg <= adc_next;
      trig_reg <= trig_next;
      g3_reg <= g3_next;
      otp_corrected_flag_reg <= otp_corrected_flag_next;
      armed_reg <= armed_next;
      pend_reg <= pend_next;
      pend_wr_reg <= pend_wr_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      cap_reg <= cap_next;
      cap_idx_reg <= cap_idx_next;
      conversion_done_pin_reg <= conversion_done_pin_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Pins and enables; in sleep only the sleep flag reaches the alert pin.
  always_comb begin
    alert_o = asleep ? alert_reg[`MSP_AL_SLEEP] : (|alert_reg);
    fault_o = !asleep && (|fault_reg);
    regulator_en_o = !asleep;
    comparator_en_o = !asleep;
    adc_en_o = (pwr_reg == PW_AWAKE) && adc_reg[`MSP_ADC_ON];
    thermistor_bias_bits_o = {io_reg[`MSP_IO_TS2], io_reg[`MSP_IO_TS1]};
    for (int i = 0; i < G3_WORDS; i++) begin
      config_o[8*i +: 8] = g3_reg[i][7:0];
    end
  end

  assign conversion_done_pin_o = conversion_done_pin_reg;
  assign rd_data_o = rdata_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_sleep_done_pin: assert property ((pwr_reg == PW_SLEEP) |=> conversion_done_pin_o)
    else $error("done pin low while asleep");
  a_sleep_no_early: assert property ((pwr_reg == PW_DRAIN && conv_busy_i) |=> pwr_reg != PW_SLEEP)
    else $error("sleep entered during a conversion");
  a_sleep_flag_set: assert property ($rose(asleep) |-> alert_reg[`MSP_AL_SLEEP] && alert_o)
    else $error("sleep flag or alert pin missing on entry");
  a_sleep_masked: assert property (asleep |-> !fault_o && (alert_o == alert_reg[`MSP_AL_SLEEP]))
    else $error("source not masked while asleep");
  a_sleep_power_off: assert property (asleep |-> !regulator_en_o && !comparator_en_o && !adc_en_o)
    else $error("power not off while asleep");
  a_bias_kept: assert property ($rose(asleep) && !$past(pend_reg) |-> $stable(thermistor_bias_bits_o))
    else $error("thermistor bias bits changed on sleep entry");
  a_warm_delay: assert property ($fell(asleep) |-> !adc_en_o [*8])
    else $error("converter enabled before warm-up");
  a_wake_restore: assert property ($fell(asleep) |-> alert_reg == $past(snap_al_reg) && comparator_en_o)
    else $error("alert contents not restored on wake");
  a_reserved_zero: assert property (rd_i && rd_addr_i == `MSP_A_RSVD |=> rd_data_o == `MSP_ZERO8)
    else $error("reserved register read not zero");
  a_crc_flag: assert property (pkt_end_i && pend_reg && !crc_ok_i && !g3_reg[`MSP_IOCFG_IDX][`MSP_CFG_CRC_DIS]
                               |=> fault_reg[`MSP_FL_CRC])
    else $error("bad CRC not flagged");
  a_g3_guarded: assert property (ot_reg == OT_IDLE && !cap_reg && !armed_reg |=> $stable(config_o))
    else $error("protected register changed without key");
  a_parity_flag: assert property (par_bad && !asleep && ot_reg != OT_LOAD |=> alert_reg[`MSP_AL_PARITY])
    else $error("parity mismatch not flagged");
  a_ecc_alert: assert property (cap_reg && otp_err |=> alert_reg[`MSP_AL_ECC_ERR] && dev_status[`MSP_DS_ALERT])
    else $error("uncorrectable error not reported");

endmodule : msp_regs

//--- tb/msp_host.sv
// Host controller model that issues register writes and reads.
// Assumes it shares clk_i with the design and drives at falling edges.
`timescale 1ns/1ps
module msp_host
  import msp_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  output logic wr_o,
  output msp_wr_s req_o,
  output logic end_o,
  output logic crc_o,
  output logic rd_o,
  output logic [7:0] ra_o
);
  // ****************
  // Bus tasks
  // ****************
  // Idle values before the first request.
  initial begin
    wr_o = 1'b0;
    req_o = 16'h0000;
    end_o = 1'b0;
    crc_o = 1'b0;
    rd_o = 1'b0;
    ra_o = 8'h00;
  end
  // One register per packet; the held fields are scrambled once released.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
    @(negedge clk_i);
    wr_o = 1'b1;
    req_o = {a, d};
    @(negedge clk_i);
    wr_o = 1'b0;
    req_o = ~req_o;
    end_o = 1'b1;
    crc_o = ok;
    @(negedge clk_i);
    end_o = 1'b0;
    crc_o = ~ok;
  endtask : wr
  // Read data is taken two cycles after the request is driven.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    ra_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    ra_o = ~a;
    @(negedge clk_i);
    d = rd_data_i;
  endtask : rd
endmodule : msp_host

//--- tb/msp_regs_tb.sv
// Bench for the register block: host model plus direct hardware inputs.
// Assumes shortened warm-up and burn counts of 8 and 20 cycles.
`timescale 1ns/1ps
`include "msp_params.svh"
module msp_regs_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic busy = 1'b0;
  logic pv = 1'b0;
  logic [7:0] fs_i = 8'h00;
  logic [7:0] as_i = 8'h00;
  logic wr, pe, ok, rd, done, alt, flt, reg_en, cmp_en, adc;
  logic [7:0] ra, rdat;
  logic [1:0] ts;
  logic [95:0] cfg;
  msp_pkg::msp_wr_s req;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  // Clock and hang limit.
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end
  msp_host host_u (.clk_i(clk_i), .rd_data_i(rdat), .wr_o(wr), .req_o(req), .end_o(pe), .crc_o(ok),
    .rd_o(rd), .ra_o(ra));
  msp_regs #(.WARM_CYC(8), .BURN_CYC(20)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr),
    .wr_req_i(req), .pkt_end_i(pe), .crc_ok_i(ok), .rd_i(rd), .rd_addr_i(ra), .rd_data_o(rdat),
    .conv_busy_i(busy), .alert_src_i(as_i), .fault_src_i(fs_i), .program_voltage_pin_i(pv),
    .conversion_done_pin_o(done), .alert_o(alt), .fault_o(flt), .regulator_en_o(reg_en),
    .comparator_en_o(cmp_en), .adc_en_o(adc), .thermistor_bias_bits_o(ts), .config_o(cfg));
  // ****************
  // Check helpers
  // ****************
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_u.rd(a, v);
    chk(v, e);
  endtask : rc
  task burn(input logic [7:0] d);
    host_u.wr(8'h3a, 8'h35, 1'b1);
    host_u.wr(8'h40, d, 1'b1);
    pv = 1'b1;
    repeat (4) @(negedge clk_i);
    host_u.wr(8'h3f, 8'h91, 1'b1);
    repeat (60) @(negedge clk_i);
    pv = 1'b0;
  endtask : burn
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (16) @(negedge clk_i);
    rc(8'h20, 8'h80);
    rc(8'h00, 8'h21);
    rc(8'h3e, 8'h00);
    rc(8'h13, 8'h00);
    rc(8'h3a, 8'h00);
    rc(8'h40, 8'h00);
    host_u.wr(8'h30, 8'h01, 1'b0);
    rc(8'h30, 8'h00);
    rc(8'h21, 8'h01);
    $display("test reset and crc done");
    host_u.wr(8'h3a, 8'h35, 1'b1);
    host_u.wr(8'h42, 8'h5a, 1'b1);
    rc(8'h42, 8'h5a);
    chk(cfg[23:16], 8'h5a);
    rc(8'h20, 8'h80);
    host_u.wr(8'h3a, 8'h35, 1'b1);
    host_u.wr(8'h30, 8'h01, 1'b1);
    host_u.wr(8'h43, 8'h11, 1'b1);
    rc(8'h43, 8'h00);
    host_u.wr(8'h3a, 8'h35, 1'b1);
    host_u.wr(8'h41, 8'h01, 1'b1);
    host_u.wr(8'h30, 8'h00, 1'b0);
    rc(8'h30, 8'h00);
    host_u.wr(8'h3a, 8'h27, 1'b1);
    repeat (14) @(negedge clk_i);
    rc(8'h42, 8'h00);
    rc(8'h41, 8'h00);
    host_u.wr(8'h30, 8'h01, 1'b1);
    $display("test protected write done");
    busy = 1'b1;
    host_u.wr(8'h31, 8'h07, 1'b1);
    repeat (2) @(negedge clk_i);
    chk({6'h0, reg_en, done}, 8'h02);
    busy = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({5'h0, done, reg_en, cmp_en}, 8'h04);
    chk({5'h0, adc, flt, alt}, 8'h01);
    chk({6'h0, ts}, 8'h03);
    fs_i = 8'h02;
    as_i = 8'h08;
    rc(8'h20, 8'h84);
    rc(8'h21, 8'h01);
    fs_i = 8'h00;
    as_i = 8'h00;
    host_u.wr(8'h20, 8'h04, 1'b1);
    host_u.wr(8'h20, 8'h00, 1'b1);
    rc(8'h20, 8'h00);
    chk({7'h0, alt}, 8'h00);
    host_u.wr(8'h31, 8'h00, 1'b1);
    @(negedge clk_i);
    chk({4'h0, reg_en, cmp_en, flt, alt}, 8'h0f);
    chk({7'h0, adc}, 8'h00);
    repeat (6) @(negedge clk_i);
    chk({7'h0, adc}, 8'h00);
    repeat (6) @(negedge clk_i);
    chk({7'h0, adc}, 8'h01);
    rc(8'h20, 8'h80);
    $display("test sleep done");
    burn(8'h3c);
    rc(8'h3f, 8'h00);
    host_u.wr(8'h3c, 8'ha5, 1'b1);
    repeat (16) @(negedge clk_i);
    rc(8'h40, 8'h3c);
    rc(8'h41, 8'h00);
    rc(8'h21, 8'h00);
    rc(8'h20, 8'h80);
    burn(8'hff);
    host_u.wr(8'h3a, 8'h27, 1'b1);
    repeat (16) @(negedge clk_i);
    rc(8'h40, 8'h3c);
    $display("test burn done");
    test_done();
  end
endmodule : msp_regs_tb
